// ---- spr_consts.svh ----
// Constants of the serial PROM read port: timing, command layout, straps.
// Assumes a 40 MHz core clock; included by bare name wherever needed.
`ifndef SPR_CONSTS_SVH
`define SPR_CONSTS_SVH

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SPR_SYS_CLK_PERIOD_NS 25
`define SPR_NVM_CLK_PERIOD_NS 1000
`define SPR_HALF_CYCLES (`SPR_NVM_CLK_PERIOD_NS / (2 * `SPR_SYS_CLK_PERIOD_NS))
`define SPR_DIV_W 5

// ----------------------------------------------------------------------
// Straps
// ----------------------------------------------------------------------
`define SPR_MASTER_ID 2'h0
`define SPR_PROM_MODE 1'h0

// ----------------------------------------------------------------------
// Command and data layout
// ----------------------------------------------------------------------
`define SPR_READ_OPCODE 3'h6
`define SPR_OPC_W 3
`define SPR_ADDR_W 6
`define SPR_CMD_W 9
`define SPR_START_ADDR 6'h00
`define SPR_WORD_W 16
`define SPR_WORDS 4
`define SPR_WADDR_W 2
`define SPR_CNT_W 5

`endif

// ---- spr_pkg.sv ----
// Types shared by the serial PROM read port modules.
// Assumes spr_consts.svh is on the include path.
`include "spr_consts.svh"

package spr_pkg;

    // ------------------------------------------------------------------
    // Sequencer phases
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {SPR_IDLE, SPR_CMD, SPR_DATA} spr_phase_e;

    // ------------------------------------------------------------------
    // Complete state of the read port
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [1:0] id_meta;
        logic [1:0] id_sync;
        logic arb_meta;
        logic arb_sync;
        logic clk_meta;
        logic clk_sync;
        logic din_meta;
        logic din_sync;
        logic pending;
        spr_phase_e phase;
        logic [`SPR_DIV_W-1:0] div_cnt;
        logic sclk;
        logic clk_oe;
        logic sel;
        logic sel_oe;
        logic cmd_out;
        logic cmd_oe;
        logic [`SPR_CMD_W-1:0] cmd_sr;
        logic [`SPR_CNT_W-1:0] bit_cnt;
        logic [`SPR_WADDR_W-1:0] word_cnt;
        logic [`SPR_WORD_W-1:0] shreg;
        logic we;
        logic [`SPR_WADDR_W-1:0] waddr;
        logic [`SPR_WORD_W-1:0] wdata;
        logic busy;
        logic done;
    } spr_state_s;

endpackage : spr_pkg

// ---- spr_prom_model.sv ----
// Behavioural serial PROM sitting on the shared board lines of the read port.
// Assumes the bench resolves every pin level; data is released outside a read.
`timescale 1ns/10ps

module spr_prom_model #(
    parameter int BITS = 64
) (
    input wire logic sclk, // Shared clock pin level
    input wire logic sel, // Select pin level
    input wire logic cmd, // Command pin level
    input wire logic [BITS-1:0] contents, // Stored bits, first word on top
    output logic dout, // Data drive value
    output logic doe, // Data drive enable
    output logic [8:0] cmd_seen // Command bits taken in this read
);
    int cnt = 0;

    initial begin
        dout = 1'b0;
        doe = 1'b0;
        cmd_seen = 9'h000;
    end

    always @(posedge sel) begin
        cnt = 0;
        cmd_seen = 9'h000;
    end

    // Released line falls to the board pull-down, not to the last bit
    always @(negedge sel) doe = 1'b0;

    always @(posedge sclk) begin
        if (sel) begin
            if (cnt < 9) cmd_seen = {cmd_seen[7:0], cmd};
            cnt = cnt + 1;
        end
    end

    // Launch on the falling edge so the bit is steady across the high phase
    always @(negedge sclk) begin
        if (sel && cnt >= 9 && cnt < 9 + BITS) begin
            doe = 1'b1;
            dout = contents[BITS - 1 - (cnt - 9)];
        end
    end
endmodule : spr_prom_model

// ---- spr_read_port.sv ----
// Serial PROM read port: fetches a block of words from a board-shared PROM.
// Assumes straps and PROM pins are asynchronous to clk; the pad ring resolves
// each pin from its output enable.
//
// Overview of operation
// [RULE1] With board position ID 00, generate a 1 MHz PROM clock for reading.
// [RULE2] Only ID 00 drives the shared clock; others tri-state and just sense it.
// [RULE3] Without a fitted PROM the board holds the shared clock line low.
// [RULE4] Select is active high, driven only by ID 00, otherwise tri-stated.
// [RULE5] Command line carries the read instruction high-active, driven only by ID 00.
// [RULE6] Data input tied statically low or high must not upset the logic.
// [RULE7] Arbitration select 0 picks PROM arbitration, 1 chain; PROM used only for 0.
// [RULE8] Board assigns up to four unique two-bit IDs, exactly one being 00.
// [RULE9] Read: raise select, shift command, sample data bits, then drop select.
`timescale 1ns/10ps
`include "spr_consts.svh"

module spr_read_port
    import spr_pkg::*;
#(
    parameter int WORD_W = `SPR_WORD_W,
    parameter int WORDS = `SPR_WORDS,
    parameter logic [`SPR_ADDR_W-1:0] START_ADDR = `SPR_START_ADDR
) (
    input wire logic clk, // 40 MHz core clock
    input wire logic resetn, // Asynchronous reset, active low
    input wire logic [1:0] board_position_id, // Position strap pins
    input wire logic arbitration_source_select, // Arbitration source strap
    input wire logic start_read, // Request a fresh read, one-cycle pulse
    input wire logic [`SPR_WADDR_W-1:0] rd_addr, // Fetched word index
    output logic [`SPR_WORD_W-1:0] rd_data, // Fetched word, one cycle after rd_addr
    input wire logic nvm_serial_clock_in, // Shared PROM clock, pin level
    output logic nvm_serial_clock_out, // PROM clock drive value
    output logic nvm_serial_clock_oe, // PROM clock drive enable
    output logic nvm_select, // PROM select drive value
    output logic nvm_select_oe, // PROM select drive enable
    output logic nvm_command_out, // PROM command drive value
    output logic nvm_command_oe, // PROM command drive enable
    input wire logic nvm_data_in, // PROM serial data pin
    output logic nvm_clock_sensed, // Synchronised shared clock level
    output logic prom_arbitration, // PROM based arbitration in force
    output logic read_busy, // Read sequence in progress
    output logic read_done // Read finished, one-cycle pulse
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    initial begin
        if (WORD_W != `SPR_WORD_W || WORDS < 1 || WORDS > (1 << `SPR_WADDR_W)) begin
            $error("spr_read_port: word geometry does not fit the state layout");
        end
        if (`SPR_HALF_CYCLES < 2 || `SPR_HALF_CYCLES >= (1 << `SPR_DIV_W)) begin
            $error("spr_read_port: clock divider out of range");
        end
    end

    localparam logic [`SPR_DIV_W-1:0] HALF_LAST = `SPR_DIV_W'(`SPR_HALF_CYCLES - 1);
    localparam logic [`SPR_CNT_W-1:0] CMD_LAST = `SPR_CNT_W'(`SPR_CMD_W - 1);
    localparam logic [`SPR_CNT_W-1:0] WORD_LAST = `SPR_CNT_W'(WORD_W - 1);
    localparam logic [`SPR_WADDR_W-1:0] WORDS_LAST = `SPR_WADDR_W'(WORDS - 1);
    localparam logic [`SPR_OPC_W-1:0] READ_OPC = `SPR_READ_OPCODE;

    spr_state_s q_ff;
    spr_state_s nxt_q;

    logic master;
    logic eligible;
    logic tick;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_q = q_ff;
        // Straps and pins pass two flops before any decision reads them
        nxt_q.id_meta = board_position_id;
        nxt_q.id_sync = q_ff.id_meta;
        nxt_q.arb_meta = arbitration_source_select;
        nxt_q.arb_sync = q_ff.arb_meta;
        nxt_q.clk_meta = nvm_serial_clock_in;
        nxt_q.clk_sync = q_ff.clk_meta;
        nxt_q.din_meta = nvm_data_in;
        nxt_q.din_sync = q_ff.din_meta;

        master = (q_ff.id_sync == `SPR_MASTER_ID);
        eligible = master && (q_ff.arb_sync == `SPR_PROM_MODE); // see [RULE7]
        tick = (q_ff.div_cnt == HALF_LAST);

        // Non-masters release every PROM line, the clock is only sensed
        nxt_q.clk_oe = master; // see [RULE2]
        nxt_q.sel_oe = master; // see [RULE4]
        nxt_q.cmd_oe = master; // see [RULE5]

        nxt_q.we = 1'b0;
        nxt_q.done = 1'b0;
        nxt_q.pending = q_ff.pending | start_read;
        nxt_q.div_cnt = tick ? '0 : q_ff.div_cnt + `SPR_DIV_W'(1); // see [RULE1]

        case (q_ff.phase)
            SPR_IDLE: begin
                nxt_q.sclk = 1'b0;
                nxt_q.sel = 1'b0;
                nxt_q.cmd_out = 1'b0;
                nxt_q.busy = 1'b0;
                if (q_ff.pending && eligible) begin
                    // see [RULE9]
                    nxt_q.pending = start_read;
                    nxt_q.phase = SPR_CMD;
                    nxt_q.sel = 1'b1;
                    nxt_q.busy = 1'b1;
                    nxt_q.div_cnt = '0;
                    nxt_q.cmd_out = READ_OPC[`SPR_OPC_W-1];
                    nxt_q.cmd_sr = {`SPR_READ_OPCODE, START_ADDR} << 1;
                    nxt_q.bit_cnt = CMD_LAST;
                    nxt_q.word_cnt = '0;
                end
            end
            SPR_CMD: begin
                // Command bits change on the falling edge, the PROM takes them on the rising one
                if (tick) begin
                    nxt_q.sclk = ~q_ff.sclk; // see [RULE1]
                    if (q_ff.sclk) begin
                        if (q_ff.bit_cnt == '0) begin
                            nxt_q.phase = SPR_DATA;
                            nxt_q.cmd_out = 1'b0;
                            nxt_q.bit_cnt = WORD_LAST;
                        end else begin
                            nxt_q.cmd_out = q_ff.cmd_sr[`SPR_CMD_W-1]; // see [RULE5] [RULE9]
                            nxt_q.cmd_sr = q_ff.cmd_sr << 1;
                            nxt_q.bit_cnt = q_ff.bit_cnt - `SPR_CNT_W'(1);
                        end
                    end
                end
            end
            SPR_DATA: begin
                // Sampling late in the high phase hides the two-flop pin latency.
                // A stuck data pin just yields all-zero or all-one words.
                if (tick) begin
                    nxt_q.sclk = ~q_ff.sclk;
                    if (q_ff.sclk) begin
                        nxt_q.shreg = {q_ff.shreg[`SPR_WORD_W-2:0], q_ff.din_sync}; // see [RULE6] [RULE9]
                        if (q_ff.bit_cnt == '0) begin
                            nxt_q.we = 1'b1;
                            nxt_q.waddr = q_ff.word_cnt;
                            nxt_q.wdata = {q_ff.shreg[`SPR_WORD_W-2:0], q_ff.din_sync};
                            nxt_q.bit_cnt = WORD_LAST;
                            if (q_ff.word_cnt == WORDS_LAST) begin
                                // see [RULE9]
                                nxt_q.phase = SPR_IDLE;
                                nxt_q.sel = 1'b0;
                                nxt_q.busy = 1'b0;
                                nxt_q.done = 1'b1;
                            end else begin
                                nxt_q.word_cnt = q_ff.word_cnt + `SPR_WADDR_W'(1);
                            end
                        end else begin
                            nxt_q.bit_cnt = q_ff.bit_cnt - `SPR_CNT_W'(1);
                        end
                    end
                end
            end
            default: begin
                nxt_q.phase = SPR_IDLE;
            end
        endcase

        // A strap change mid-read abandons it and keeps the request for later
        if (q_ff.phase != SPR_IDLE && !eligible) begin
            nxt_q.phase = SPR_IDLE;
            nxt_q.sclk = 1'b0;
            nxt_q.sel = 1'b0;
            nxt_q.cmd_out = 1'b0;
            nxt_q.busy = 1'b0;
            nxt_q.done = 1'b0;
            nxt_q.we = 1'b0;
            nxt_q.pending = 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            q_ff <= '0;
            q_ff.id_meta <= 2'h3;
            q_ff.id_sync <= 2'h3;
            q_ff.arb_meta <= 1'h1;
            q_ff.arb_sync <= 1'h1;
            q_ff.pending <= 1'h1;
            q_ff.phase <= SPR_IDLE;
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign nvm_serial_clock_out = q_ff.sclk;
    assign nvm_serial_clock_oe = q_ff.clk_oe;
    assign nvm_select = q_ff.sel;
    assign nvm_select_oe = q_ff.sel_oe;
    assign nvm_command_out = q_ff.cmd_out;
    assign nvm_command_oe = q_ff.cmd_oe;
    assign nvm_clock_sensed = q_ff.clk_sync; // see [RULE2]
    assign prom_arbitration = ~q_ff.arb_sync;
    assign read_busy = q_ff.busy;
    assign read_done = q_ff.done;

    // ------------------------------------------------------------------
    // Fetched word storage
    // ------------------------------------------------------------------
    spr_word_store #(
        .WORD_W(`SPR_WORD_W),
        .DEPTH(WORDS),
        .ADDR_W(`SPR_WADDR_W)
    ) u_store (
        .clk(clk),
        .we(q_ff.we),
        .waddr(q_ff.waddr),
        .wdata(q_ff.wdata),
        .raddr(rd_addr),
        .rdata(rd_data)
    );

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    localparam int READ_BOUND = (`SPR_CMD_W + WORDS * WORD_W) * 2 * `SPR_HALF_CYCLES + 4;
    int busy_cycles_ff;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            busy_cycles_ff <= 0;
        end else begin
            busy_cycles_ff <= q_ff.busy ? busy_cycles_ff + 1 : 0;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_clk_high_half;
        $rose(nvm_serial_clock_out) && eligible |-> ##19 nvm_serial_clock_out ##1 !nvm_serial_clock_out;
    endproperty
    a_clk_high_half: assert property (p_clk_high_half) else $error("PROM clock high phase not 20 cycles"); // see [RULE1]

    property p_first_rise;
        $rose(nvm_select) |-> !nvm_serial_clock_out [*8] ##13 nvm_serial_clock_out;
    endproperty
    a_first_rise: assert property (p_first_rise) else $error("First PROM clock rise misplaced"); // see [RULE1]

    property p_clk_oe_master;
        (q_ff.id_sync != `SPR_MASTER_ID) |=> !nvm_serial_clock_oe && !nvm_command_oe;
    endproperty
    a_clk_oe_master: assert property (p_clk_oe_master) else $error("Non-master drives PROM lines"); // see [RULE2]

    property p_sel_driven;
        nvm_select |-> nvm_select_oe && (q_ff.id_sync == `SPR_MASTER_ID);
    endproperty
    a_sel_driven: assert property (p_sel_driven) else $error("Select high while not master"); // see [RULE4]

    property p_cmd_in_frame;
        nvm_command_out |-> nvm_select && nvm_command_oe;
    endproperty
    a_cmd_in_frame: assert property (p_cmd_in_frame) else $error("Command high outside select"); // see [RULE5]

    property p_read_bounded;
        busy_cycles_ff <= READ_BOUND;
    endproperty
    a_read_bounded: assert property (p_read_bounded) else $error("Read did not finish in time"); // see [RULE6]

    property p_prom_mode_only;
        $rose(nvm_select) |-> $past(q_ff.arb_sync) == `SPR_PROM_MODE;
    endproperty
    a_prom_mode_only: assert property (p_prom_mode_only) else $error("Read started in chain mode"); // see [RULE7]

    property p_sel_end_done;
        $fell(nvm_select) && eligible |-> read_done && !read_busy ##1 !read_done;
    endproperty
    a_sel_end_done: assert property (p_sel_end_done) else $error("Select dropped without completion"); // see [RULE9]

endmodule : spr_read_port

// ---- spr_word_store.sv ----
// Small word memory holding the PROM contents fetched by the read port.
// Assumes one writer and one reader on the same clock; read data registered.
`timescale 1ns/10ps

module spr_word_store #(
    parameter int WORD_W = 16,
    parameter int DEPTH = 4,
    parameter int ADDR_W = 2
) (
    input wire logic clk, // Core clock
    input wire logic we, // Write strobe
    input wire logic [ADDR_W-1:0] waddr, // Write address
    input wire logic [WORD_W-1:0] wdata, // Write data
    input wire logic [ADDR_W-1:0] raddr, // Read address
    output logic [WORD_W-1:0] rdata // Registered read data
);

    initial begin
        if (DEPTH < 1 || DEPTH > (1 << ADDR_W) || WORD_W < 1) begin
            $error("spr_word_store: unsupported geometry");
        end
    end

    logic [WORD_W-1:0] mem [DEPTH];

    // No reset: contents are only meaningful after a completed read
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule : spr_word_store

// ---- tb_spr_read_port.sv ----
// Self-checking bench of the serial PROM read port with a behavioural PROM.
// Assumes the design's default of four 16-bit words and the 40 MHz clock.
`timescale 1ns/10ps
`include "spr_consts.svh"

module tb_spr_read_port;
    import spr_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [1:0] id = 2'h0;
    logic arb = 1'b0;
    logic start_read = 1'b0;
    logic [`SPR_WADDR_W-1:0] rd_addr = '0;
    logic [`SPR_WORD_W-1:0] rd_data;
    logic clk_out, clk_oe, sel, sel_oe, cmd, cmd_oe, sensed, prom_arb, busy, done;
    logic dout, doe, ext_en = 1'b0, ext_clk = 1'b0, rd_chk = 1'b0, chk_d = 1'b0;
    logic [8:0] cmd_seen;
    logic [63:0] contents = 64'h0000_0000_0000_0000;
    logic [1:0] data_mode = 2'h0;
    logic [`SPR_WORD_W-1:0] q[$];
    int fails = 0;
    int tests_run = 0;
    int seed = 32'hfd907ff2;
    int cnt;
    int sel_cycles = 0;
    logic sensed_d;
    // ------------------------------------------------------------------
    // Pins, with the board pull-downs when nobody drives
    // ------------------------------------------------------------------
    wire pin_clk = clk_oe ? clk_out : (ext_en & ext_clk);
    wire pin_sel = sel_oe & sel;
    wire pin_cmd = cmd_oe & cmd;
    wire pin_din = data_mode == 2'h1 ? 1'b0 : data_mode == 2'h2 ? 1'b1 : (doe & dout);

    always #12.5 clk = ~clk;
    initial begin
        #7;
        forever #100 ext_clk = ~ext_clk;
    end

    spr_read_port spr_read_port_inst (.clk(clk), .resetn(resetn), .board_position_id(id),
        .arbitration_source_select(arb), .start_read(start_read), .rd_addr(rd_addr), .rd_data(rd_data),
        .nvm_serial_clock_in(pin_clk), .nvm_serial_clock_out(clk_out), .nvm_serial_clock_oe(clk_oe),
        .nvm_select(sel), .nvm_select_oe(sel_oe), .nvm_command_out(cmd), .nvm_command_oe(cmd_oe),
        .nvm_data_in(pin_din), .nvm_clock_sensed(sensed), .prom_arbitration(prom_arb),
        .read_busy(busy), .read_done(done));
    spr_prom_model #(.BITS(64)) spr_prom_model_inst (.sclk(pin_clk), .sel(pin_sel), .cmd(pin_cmd),
        .contents(contents), .dout(dout), .doe(doe), .cmd_seen(cmd_seen));

    task check(input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task test_done;
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done

    task pulse_start;
        @(posedge clk) start_read <= 1'b1;
        @(posedge clk) start_read <= 1'b0;
    endtask : pulse_start

    // One whole read: timing and wire counts, then the stored words
    task run_read(input logic [63:0] exp, input logic rearm);
        int n, hi, rises;
        logic prev;
        n = 0;
        hi = 0;
        rises = 0;
        prev = 1'b0;
        for (int i = 0; i < 100 && sel !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        check({sel, busy, clk_oe, sel_oe, cmd_oe}, 5'h1f);
        while (done !== 1'b1 && n < 4000) begin
            @(posedge clk);
            start_read <= rearm && n == 100;
            #1;
            n++;
            hi += clk_out;
            rises += clk_out & ~prev;
            prev = clk_out;
        end
        // A re-armed read may already be under way on entry, so the frame length comes from sel_cycles
        check(sel_cycles >= 2919 && sel_cycles <= 2921, 1);
        check(sel, 0);
        check(hi, 1460);
        check(rises, 73);
        check(cmd_seen, 9'h180);
        repeat (3) @(posedge clk);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            rd_addr <= k;
            rd_chk <= 1'b1;
            q.push_back(exp[63 - 16 * k -: 16]);
        end
        @(posedge clk) rd_chk <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : run_read

    // ------------------------------------------------------------------
    // Result monitor: oldest note against each word read back
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        chk_d <= rd_chk;
        if (chk_d) check(rd_data, q.pop_front());
    end

    // Cycles since select rose, as the read's length
    always @(posedge clk) begin
        sel_cycles <= sel ? sel_cycles + 1 : 0;
    end

    initial begin
        #2_000_000;
        fails++;
        test_done;
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        contents = {$random(seed), $random(seed)};
        repeat (4) @(posedge clk);
        #1;
        check({clk_oe, sel_oe, cmd_oe, busy, done}, 5'h00);
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        // Sole master on the board, PROM arbitration: read starts by itself
        run_read(contents, 1'b1);
        check(prom_arb, 1);
        run_read(contents, 1'b0);
        contents = {$random(seed), $random(seed)};
        pulse_start;
        run_read(contents, 1'b0);
        // Data pin tied statically low, then high
        @(posedge clk) data_mode <= 2'h1;
        pulse_start;
        run_read(64'h0000_0000_0000_0000, 1'b0);
        @(posedge clk) data_mode <= 2'h2;
        arb <= 1'b1;
        repeat (5) @(posedge clk);
        check(prom_arb, 0);
        pulse_start;
        cnt = 0;
        repeat (200) @(posedge clk) cnt += sel;
        check(cnt, 0);
        @(posedge clk) arb <= 1'b0;
        run_read(64'hffff_ffff_ffff_ffff, 1'b0);
        // Another device masters the clock; this one only senses it
        @(posedge clk) id <= 2'h1;
        pulse_start;
        repeat (5) @(posedge clk);
        ext_en <= 1'b1;
        cnt = 0;
        sensed_d = sensed;
        for (int i = 0; i < 80; i++) begin
            @(posedge clk);
            #1;
            cnt += sensed != sensed_d;
            sensed_d = sensed;
            check({clk_oe, sel_oe, cmd_oe, sel}, 4'h0);
        end
        check(cnt >= 19 && cnt <= 21, 1);
        test_done;
    end
endmodule : tb_spr_read_port
